// ---- hdl/vcc_pkg.sv ----
package vcc_pkg;

	// Bus geometry.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] CTRL_IDX = 8'h9B;
	localparam logic [7:0] MODE_IDX = 8'h9D;
	localparam logic [7:0] MUX_IDX  = 8'h9F;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] MUX_ADDR  = {2'h0, MUX_IDX, 2'h0};

	// Field positions in compare_control.
	localparam int CTRL_EN_BIT   = 7;
	localparam int CTRL_OUT_BIT  = 6;
	localparam int CTRL_RISE_BIT = 5;
	localparam int CTRL_FALL_BIT = 4;
	localparam int CTRL_PHYS_LSB = 2;
	localparam int CTRL_NHYS_LSB = 0;

	// Field positions in compare_mode_reg.
	localparam int MODE_RIE_BIT = 5;
	localparam int MODE_FIE_BIT = 4;
	localparam int MODE_RT_LSB  = 0;

	// Field positions in compare_input_select.
	localparam int MUX_NEG_LSB = 4;
	localparam int MUX_POS_LSB = 0;

	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h02;
	localparam logic [7:0] MUX_RST  = 8'hFF;

	// Hysteresis settings passed to the analog core.
	typedef enum logic [1:0] {
		HYS_OFF  = 2'h0,
		HYS_5MV  = 2'h1,
		HYS_10MV = 2'h2,
		HYS_20MV = 2'h3
	} vcc_hys_t;

	// Response time, fastest to slowest.
	typedef enum logic [1:0] {
		RT_MODE0 = 2'h0,
		RT_MODE1 = 2'h1,
		RT_MODE2 = 2'h2,
		RT_MODE3 = 2'h3
	} vcc_rt_t;

	// Bus slave states.
	typedef enum logic {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} vcc_bus_st_t;

	// APB request from the master.
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} vcc_apb_req_t;

	// APB answer to the master.
	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} vcc_apb_rsp_t;

	// Settings for the analog comparator core.
	typedef struct packed {
		logic       enable;
		vcc_hys_t   pos_hyst;
		vcc_hys_t   neg_hyst;
		vcc_rt_t    resp_time;
		logic [7:0] pos_sel;
		logic [7:0] neg_sel;
	} vcc_analog_ctrl_t;

endpackage

// ---- hdl/vcc_sync.sv ----
`timescale 1ns/100ps
// Two-stage level synchroniser; the first stage feeds only the second.
module vcc_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset.
	input  wire logic mclk_in,
	input  wire logic rst_in,
	// Level in and out.
	input  wire logic d_in,
	output logic      q_out
);
	logic [STAGES-1:0] chain;

	// Shift the asynchronous level through the chain.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], d_in};
		end
	end

	assign q_out = chain[STAGES-1];
endmodule

// ---- hdl/vcc_input_decode.sv ----
`timescale 1ns/100ps
// Turns an input-select code into a one-hot pin select.
module vcc_input_decode #(
	parameter int CODE_W = 4,
	parameter int SEL_W  = 8
) (
	// Code from the register.
	input  wire logic [CODE_W-1:0] code_in,
	// One-hot select, all zero for no input.
	output logic      [SEL_W-1:0]  sel_out
);
	// A set top bit selects nothing, so the core sees no pin at all.
	always_comb begin
		sel_out = '0;
		if (!code_in[CODE_W-1]) begin
			sel_out[code_in[CODE_W-2:0]] = 1'b1;
		end
	end
endmodule

// ---- hdl/vcc_top.sv ----
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module vcc_top
	import vcc_pkg::*;
(
	// Clock and reset.
	input  wire logic                      mclk_in,
	input  wire logic                      rst_in,
	// APB slave port.
	input  wire vcc_pkg::vcc_apb_req_t     apb_req_in,
	output vcc_pkg::vcc_apb_rsp_t          apb_rsp_out,
	// Analog comparator core.
	input  wire logic                      analog_result_in,
	output vcc_pkg::vcc_analog_ctrl_t      analog_ctrl_out,
	// Pin, interrupt and reset outputs.
	output logic                           latched_compare_out,
	output logic                           raw_compare_out,
	output logic                           irq_out,
	output logic                           reset_source_out
);
	import vcc_pkg::*;

	// Control fields.
	logic        compare_enable;
	vcc_hys_t    pos_hysteresis_sel;
	vcc_hys_t    neg_hysteresis_sel;
	logic        rise_edge_flag;
	logic        fall_edge_flag;
	logic        rise_irq_enable;
	logic        fall_irq_enable;
	vcc_rt_t     response_time_sel;
	logic [3:0]  neg_input_sel;
	logic [3:0]  pos_input_sel;

	// Bus slave state.
	vcc_bus_st_t bus_state;
	vcc_bus_st_t next_bus_state;
	logic        acc_done;
	logic        wr_ctrl;
	logic        wr_mode;
	logic        wr_mux;
	logic [7:0]  rd_value;
	logic        rd_hit;

	// Comparator level path.
	logic        sync_level;
	logic        lvl_now;
	logic        rise_evt;
	logic        fall_evt;
	logic [7:0]  pos_sel_dec;
	logic [7:0]  neg_sel_dec;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// A write takes effect only at the edge where pready is seen high.
	assign acc_done = apb_req_in.psel & apb_req_in.penable & apb_rsp_out.pready;
	assign wr_ctrl  = acc_done & apb_req_in.pwrite
		& (apb_req_in.paddr == CTRL_ADDR);
	assign wr_mode  = acc_done & apb_req_in.pwrite
		& (apb_req_in.paddr == MODE_ADDR);
	assign wr_mux   = acc_done & apb_req_in.pwrite
		& (apb_req_in.paddr == MUX_ADDR);

	// Read decode; unmapped addresses answer zero with an error.
	always_comb begin
		rd_value = 8'h00;
		rd_hit   = 1'b1;
		unique case (apb_req_in.paddr)
			CTRL_ADDR: begin
				rd_value = {compare_enable, latched_compare_out, rise_edge_flag,
					fall_edge_flag, pos_hysteresis_sel, neg_hysteresis_sel};
			end
			MODE_ADDR: begin
				rd_value = {2'h0, rise_irq_enable, fall_irq_enable, 2'h0,
					response_time_sel};
			end
			MUX_ADDR: begin
				rd_value = {neg_input_sel, pos_input_sel};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// One wait state: the answer state is entered on the access phase.
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			BUS_IDLE: begin
				if (apb_req_in.psel && apb_req_in.penable) begin
					next_bus_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// Bus state register.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// Answer register; read data is captured with pready so it is stable.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			apb_rsp_out <= '0;
		end else if (next_bus_state == BUS_ANSWER) begin
			apb_rsp_out.pready  <= 1'b1;
			apb_rsp_out.pslverr <= ~rd_hit;
			apb_rsp_out.prdata  <= apb_req_in.pwrite ? '0
				: {{(DATA_W-8){1'b0}}, rd_value};
		end else begin
			apb_rsp_out <= '0;
		end
	end

	// Control register fields other than the flags.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			compare_enable     <= CTRL_RST[CTRL_EN_BIT];
			pos_hysteresis_sel <= vcc_hys_t'(CTRL_RST[CTRL_PHYS_LSB +: 2]);
			neg_hysteresis_sel <= vcc_hys_t'(CTRL_RST[CTRL_NHYS_LSB +: 2]);
		end else if (wr_ctrl) begin
			compare_enable     <= apb_req_in.pwdata[CTRL_EN_BIT];
			pos_hysteresis_sel <=
				vcc_hys_t'(apb_req_in.pwdata[CTRL_PHYS_LSB +: 2]);
			neg_hysteresis_sel <=
				vcc_hys_t'(apb_req_in.pwdata[CTRL_NHYS_LSB +: 2]);
		end
	end

	// Mode register.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rise_irq_enable   <= MODE_RST[MODE_RIE_BIT];
			fall_irq_enable   <= MODE_RST[MODE_FIE_BIT];
			response_time_sel <= vcc_rt_t'(MODE_RST[MODE_RT_LSB +: 2]);
		end else if (wr_mode) begin
			rise_irq_enable   <= apb_req_in.pwdata[MODE_RIE_BIT];
			fall_irq_enable   <= apb_req_in.pwdata[MODE_FIE_BIT];
			response_time_sel <=
				vcc_rt_t'(apb_req_in.pwdata[MODE_RT_LSB +: 2]);
		end
	end

	// Input select register.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			neg_input_sel <= MUX_RST[MUX_NEG_LSB +: 4];
			pos_input_sel <= MUX_RST[MUX_POS_LSB +: 4];
		end else if (wr_mux) begin
			neg_input_sel <= apb_req_in.pwdata[MUX_NEG_LSB +: 4];
			pos_input_sel <= apb_req_in.pwdata[MUX_POS_LSB +: 4];
		end
	end

	// The analog result is asynchronous, so it is synchronised first.
	vcc_sync #(
		.STAGES (2)
	) u_sync (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.d_in    (analog_result_in),
		.q_out   (sync_level)
	);

	assign lvl_now  = sync_level & compare_enable;
	assign rise_evt = lvl_now & ~latched_compare_out;
	assign fall_evt = ~lvl_now & latched_compare_out;

	// Latched output and reset source both follow the synced level gated by the enable.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			latched_compare_out <= 1'b0;
			reset_source_out    <= 1'b0;
		end else begin
			latched_compare_out <= lvl_now;
			reset_source_out    <= lvl_now;
		end
	end

	// clockless gated path
	// The raw path has no flop so it keeps working with the clock stopped.
	assign raw_compare_out = analog_result_in & compare_enable;

	// Sticky flags; a hardware edge in the clearing cycle still sets.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rise_edge_flag <= CTRL_RST[CTRL_RISE_BIT];
			fall_edge_flag <= CTRL_RST[CTRL_FALL_BIT];
		end else begin
			rise_edge_flag <= rise_evt
				| (wr_ctrl ? apb_req_in.pwdata[CTRL_RISE_BIT] : rise_edge_flag);
			fall_edge_flag <= fall_evt
				| (wr_ctrl ? apb_req_in.pwdata[CTRL_FALL_BIT] : fall_edge_flag);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= (rise_edge_flag & rise_irq_enable)
				| (fall_edge_flag & fall_irq_enable);
		end
	end

	vcc_input_decode #(
		.CODE_W (4),
		.SEL_W  (8)
	) u_pos_dec (
		.code_in (pos_input_sel),
		.sel_out (pos_sel_dec)
	);

	vcc_input_decode #(
		.CODE_W (4),
		.SEL_W  (8)
	) u_neg_dec (
		.code_in (neg_input_sel),
		.sel_out (neg_sel_dec)
	);

	// Settings to the core are registered, costing one cycle of delay.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			analog_ctrl_out <= '0;
		end else begin
			analog_ctrl_out.enable    <= compare_enable;
			analog_ctrl_out.pos_hyst  <= pos_hysteresis_sel;
			analog_ctrl_out.neg_hyst  <= neg_hysteresis_sel;
			analog_ctrl_out.resp_time <= response_time_sel;
			analog_ctrl_out.pos_sel   <= pos_sel_dec;
			analog_ctrl_out.neg_sel   <= neg_sel_dec;
		end
	end

	// Access phase followed by the answer one cycle later.
	sequence acc_wait_s;
		apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready;
	endsequence

	sequence ctrl_read_s;
		acc_wait_s and (!apb_req_in.pwrite && apb_req_in.paddr == CTRL_ADDR);
	endsequence

	bus_one_wait_a: assert property (
		acc_wait_s |=> apb_rsp_out.pready ##1 !apb_rsp_out.pready)
		else $error("pready not one cycle after access");

	result_read_a: assert property (
		ctrl_read_s ##1 apb_rsp_out.pready
			|-> apb_rsp_out.prdata[CTRL_OUT_BIT] == $past(latched_compare_out))
		else $error("result bit read wrong");

	enable_write_a: assert property (
		wr_ctrl |=> compare_enable == $past(apb_req_in.pwdata[CTRL_EN_BIT]))
		else $error("enable bit not written");

	rise_flag_set_a: assert property (
		$rose(sync_level) && compare_enable
			|=> rise_edge_flag)
		else $error("rising edge not flagged");

	fall_flag_set_a: assert property (
		fall_evt |=> fall_edge_flag)
		else $error("falling edge not flagged");

	flag_sticky_a: assert property (
		rise_edge_flag && !wr_ctrl |=> rise_edge_flag)
		else $error("rise flag cleared by hardware");

	set_beats_clear_a: assert property (
		fall_evt && wr_ctrl && !apb_req_in.pwdata[CTRL_FALL_BIT]
			|=> fall_edge_flag)
		else $error("clear won over edge");

	irq_mask_a: assert property (
		irq_out == $past((rise_edge_flag && rise_irq_enable)
			|| (fall_edge_flag && fall_irq_enable)))
		else $error("interrupt request mismatch");

	disabled_low_a: assert property (
		!compare_enable |-> !raw_compare_out ##1 !latched_compare_out)
		else $error("output high while disabled");

	mode_reset_a: assert property (
		$fell(rst_in) |-> {2'h0, rise_irq_enable, fall_irq_enable, 2'h0,
			response_time_sel} == MODE_RST)
		else $error("mode register reset value wrong");

	no_input_a: assert property (
		pos_input_sel[3] |-> pos_sel_dec == 8'h00
			##1 analog_ctrl_out.pos_sel == 8'h00)
		else $error("no-input code selects a pin");

	neg_pin_a: assert property (
		!neg_input_sel[3] |-> neg_sel_dec == (8'h01 << neg_input_sel[2:0]))
		else $error("negative select decode wrong");

	resp_time_a: assert property (
		wr_mode |=> ##1 analog_ctrl_out.resp_time
			== $past(apb_req_in.pwdata[1:0], 2))
		else $error("response time not passed to core");

	reset_feed_a: assert property (
		reset_source_out == latched_compare_out)
		else $error("reset source differs from result");
endmodule

// ---- test/vcc_core_model.sv ----
`timescale 1ns/100ps
// Behavioural analog core; each pin level is a digital stand-in for a voltage.
module vcc_core_model
	import vcc_pkg::*;
(
	// Settings from the block.
	input  wire vcc_pkg::vcc_analog_ctrl_t ctrl_in,
	// Separate buses: pos_pin_in feeds the positive side, neg_pin_in the negative side.
	input  wire logic [7:0]                pos_pin_in,
	input  wire logic [7:0]                neg_pin_in,
	// Comparator decision.
	output logic                           result_out
);
	logic pos_hi;
	logic neg_hi;

	// An unselected input reads low, so with no positive input the result stays low.
	assign pos_hi = |(ctrl_in.pos_sel & pos_pin_in);
	assign neg_hi = |(ctrl_in.neg_sel & neg_pin_in);
	// A powered-down core cannot decide, so it reports low.
	assign result_out = ctrl_in.enable & pos_hi & ~neg_hi;
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
// Self-checking bench for the comparator control block.
module tb_top;
	import vcc_pkg::*;
	logic             mclk_in;
	logic             rst_in;
	vcc_apb_req_t     req;
	vcc_apb_rsp_t     rsp;
	logic             res;
	vcc_analog_ctrl_t actl;
	logic             latched;
	logic             raw;
	logic             irq;
	logic             rsrc;
	logic [7:0]       pos_pins;
	logic [7:0]       neg_pins;
	int               err_total;
	int               check_count;
	int               cyc;

	vcc_top u_vcc_top (
		.mclk_in            (mclk_in),
		.rst_in             (rst_in),
		.apb_req_in         (req),
		.apb_rsp_out        (rsp),
		.analog_result_in   (res),
		.analog_ctrl_out    (actl),
		.latched_compare_out(latched),
		.raw_compare_out    (raw),
		.irq_out            (irq),
		.reset_source_out   (rsrc)
	);

	vcc_core_model u_vcc_core_model (
		.ctrl_in   (actl),
		.pos_pin_in(pos_pins),
		.neg_pin_in(neg_pins),
		.result_out(res)
	);

	// Free-running 100 MHz clock.
	initial begin
		mclk_in = 1'b0;
	end
	always #5 mclk_in = ~mclk_in;

	// Ends a hung run; the whole sequence needs well under a thousand cycles.
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, ex, got);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask

	// Ready, read data and error are taken at the rising edge that sees ready.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge mclk_in);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= w;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge mclk_in);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {24'h0, d}, r, e);
		chk("write error", 32'h0, e);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] ex);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk("read data", {24'h0, ex}, r);
	endtask

	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		rdc(CTRL_ADDR, CTRL_RST);
		rdc(MODE_ADDR, 8'h02);
		rdc(MUX_ADDR, MUX_RST);
		chk("resp time", 32'h2, actl.resp_time);
		wr(MODE_ADDR, 8'hFF);
		rdc(MODE_ADDR, 8'h33);
		wr(MODE_ADDR, 8'h02);
		wr(CTRL_ADDR, 8'h40);
		rdc(CTRL_ADDR, 8'h00);
		apb(1'b0, 12'h004, 32'h0, r, e);
		chk("unmapped error", 32'h1, e);
		chk("unmapped data", 32'h0, r);
		$display("test reset done");
	endtask

	// Pos code i against neg code 8-i, so swapped fields cannot pass.
	task automatic t_mux;
		logic [3:0] p;
		logic [3:0] n;
		for (int i = 0; i < 9; i++) begin
			p = 4'(i);
			n = 4'(8 - i);
			wr(MUX_ADDR, {n, p});
			wait_cyc(2);
			chk("pos sel", p[3] ? 8'h00 : 8'h01 << p[2:0], actl.pos_sel);
			chk("neg sel", n[3] ? 8'h00 : 8'h01 << n[2:0], actl.neg_sel);
		end
		$display("test mux done");
	endtask

	task automatic t_hys;
		logic [1:0] h;
		for (int i = 0; i < 4; i++) begin
			h = 2'(i);
			wr(CTRL_ADDR, {4'h0, h, ~h});
			wait_cyc(2);
			chk("pos hyst", {30'h0, h}, actl.pos_hyst);
			chk("neg hyst", {30'h0, ~h}, actl.neg_hyst);
			rdc(CTRL_ADDR, {4'h0, h, ~h});
		end
		$display("test hysteresis done");
	endtask

	task automatic t_edges;
		wr(MUX_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h80);
		wait_cyc(6);
		wr(CTRL_ADDR, 8'h80);
		wr(MODE_ADDR, 8'h23);
		wait_cyc(2);
		chk("resp time", 32'h3, actl.resp_time);
		pos_pins <= 8'h01;
		wait_cyc(6);
		chk("latched", 32'h1, latched);
		chk("reset src", 32'h1, rsrc);
		chk("irq rise", 32'h1, irq);
		rdc(CTRL_ADDR, 8'hE0);
		wait_cyc(10);
		rdc(CTRL_ADDR, 8'hE0);
		wr(CTRL_ADDR, 8'h80);
		wr(MODE_ADDR, 8'h10);
		wait_cyc(2);
		chk("irq cleared", 32'h0, irq);
		rdc(CTRL_ADDR, 8'hC0);
		@(posedge mclk_in);
		pos_pins <= 8'h00;
		#1;
		// The raw path must move before any further clock edge.
		chk("raw early", 32'h0, raw);
		chk("latched late", 32'h1, latched);
		wait_cyc(6);
		chk("irq fall", 32'h1, irq);
		rdc(CTRL_ADDR, 8'h90);
		pos_pins <= 8'h01;
		wait_cyc(6);
		chk("raw on", 32'h1, raw);
		rdc(CTRL_ADDR, 8'hF0);
		// The falling edge lands on the same edge as the flag clear.
		fork
			wr(CTRL_ADDR, 8'h80);
			begin
				@(posedge mclk_in);
				pos_pins <= 8'h00;
			end
		join
		rdc(CTRL_ADDR, 8'h90);
		pos_pins <= 8'h01;
		wait_cyc(6);
		wr(CTRL_ADDR, 8'h00);
		wait_cyc(6);
		chk("latched off", 32'h0, latched);
		chk("raw off", 32'h0, raw);
		$display("test edges done");
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		err_total   = 0;
		check_count = 0;
		cyc         = 0;
		rst_in      = 1'b1;
		req         = '0;
		pos_pins    = 8'h00;
		neg_pins    = 8'h00;
		wait_cyc(10);
		rst_in <= 1'b0;
		wait_cyc(2);
		t_reset();
		t_mux();
		t_hys();
		t_edges();
		give_verdict();
	end
endmodule
